// >>> hdl/efpc_pkg.sv
// package: constants and types of the earth fault phase classifier
package efpc_pkg;
	localparam int CUR_W             = 16;
	localparam int ANG_W             = 9;
	localparam int TS_W              = 48;
	localparam int PCT_W             = 8;
	localparam int MS_W              = 20;
	localparam int CNT_W             = 16;
	localparam int SEL_W             = 8;
	localparam int PHASES            = 3;
	localparam int GROUPS            = 4;
	localparam int LOG_DEPTH         = 8;
	localparam int CLOCK_PERIOD_NS   = 20;
	localparam int TICK_PERIOD_US    = 1000;
	localparam int TICK_CYCLES       = TICK_PERIOD_US * 1000 / CLOCK_PERIOD_NS;
	localparam int FORCE_TIMEOUT_MIN = 5;
	localparam int FORCE_TIMEOUT_MS  = FORCE_TIMEOUT_MIN * 60 * 1000;
	localparam int K_SCALE           = 100;

	localparam logic signed [ANG_W-1:0] ANG_CONFIRM = 9'sh03c;
	localparam logic signed [ANG_W-1:0] ANG_CAP     = 9'sh05a;
	localparam logic signed [ANG_W-1:0] ANG_REVERSE = 9'sh0b4;
	localparam logic signed [ANG_W:0]   ANG_HALF    = 10'sh0b4;
	localparam logic signed [ANG_W:0]   ANG_FULL    = 10'sh168;
	localparam logic [PCT_W-1:0]        PCT_FULL    = 8'h64;

	typedef enum logic [3:0] {
		OUT_NONE, OUT_FORWARD_L1, OUT_FORWARD_L2, OUT_FORWARD_L3,
		OUT_FORWARD_L12, OUT_FORWARD_L23, OUT_FORWARD_L31, OUT_FORWARD_L123,
		OUT_REVERSE_ONE, OUT_REVERSE_TWO, OUT_REVERSE_THREE
	} efpc_outcome_type;

	typedef enum logic [1:0] {
		SRC_INPUT_ONE, SRC_INPUT_TWO, SRC_PHASE_SUM
	} efpc_source_type;

	typedef enum logic [2:0] {
		SEL_NONE, SEL_DIGITAL, SEL_VIRTUAL_IN, SEL_INDICATOR, SEL_VIRTUAL_OUT
	} efpc_select_type;

	typedef struct packed {
		logic [CUR_W-1:0] pickup;
		logic [MS_W-1:0]  operateMs;
		logic [7:0]       multiplier;
		logic             definiteTime;
		logic             capacitive;
	} efpc_group_type;

	typedef struct packed {
		logic [TS_W-1:0]  stamp;
		logic [CUR_W-1:0] maxCurrent;
		logic [PCT_W-1:0] elapsedPct;
		logic [1:0]       group;
		efpc_outcome_type outcome;
	} efpc_record_type;

	function automatic logic signed [ANG_W-1:0] angDiff(
		input logic signed [ANG_W-1:0] a,
		input logic signed [ANG_W-1:0] b
	);
		logic signed [ANG_W:0] d;
		d = ANG_W'(0) + a - b;
		if (d > ANG_HALF) begin
			d = d - ANG_FULL;
		end else if (d < -ANG_HALF) begin
			d = d + ANG_FULL;
		end
		return d[ANG_W-1:0];
	endfunction : angDiff

	function automatic logic signed [ANG_W-1:0] angAbs(input logic signed [ANG_W-1:0] a);
		return (a < 0) ? -a : a;
	endfunction : angAbs
endpackage : efpc_pkg

// >>> hdl/efpc_fault_log.sv
// module: fault record store, newest entry at index zero
module efpc_fault_log
	import efpc_pkg::*;
#(
	parameter int DEPTH = LOG_DEPTH,
	localparam int AW   = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          reset_n,
	// write side
	input  wire logic          writeEn,
	input  efpc_record_type    writeData,
	// read side
	input  wire logic [AW-1:0] readIndex,
	output efpc_record_type    readData,
	output logic [AW:0]        entryCount
);
	if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_check
		$error("fault log depth must be a power of two");
	end

	efpc_record_type mem [DEPTH];
	logic [AW-1:0]   wrPtr_reg, wrPtr_next;
	logic [AW:0]     count_reg, count_next;
	efpc_record_type readData_reg, readData_next;
	logic [AW-1:0]   slot;

	always_comb begin
		wrPtr_next    = wrPtr_reg;
		count_next    = count_reg;
		slot          = wrPtr_reg - 1'b1 - readIndex;
		readData_next = ({1'b0, readIndex} < count_reg) ? mem[slot] : '0;
		if (writeEn) begin
			wrPtr_next = wrPtr_reg + 1'b1;
			if (count_reg != (AW+1)'(DEPTH)) begin
				count_next = count_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (writeEn) begin
			mem[wrPtr_reg] <= writeData;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_reg    <= '0;
			count_reg    <= '0;
			readData_reg <= '0;
		end else begin
			wrPtr_reg    <= wrPtr_next;
			count_reg    <= count_next;
			readData_reg <= readData_next;
		end
	end

	assign readData   = readData_reg;
	assign entryCount = count_reg;
endmodule : efpc_fault_log

// >>> hdl/efpc_classifier.sv
// module: earth fault stage decisions, phase classification and fault records
module efpc_classifier
	import efpc_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES,
	parameter int FORCE_MS_P    = FORCE_TIMEOUT_MS
) (
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      reset_n,
	// residual measurements
	input  wire logic [CUR_W-1:0]          residualInputOne,
	input  wire logic [CUR_W-1:0]          residualInputTwo,
	input  wire logic [CUR_W-1:0]          residualFromPhaseSum,
	input  efpc_source_type                residualSource,
	// phase deltas and angles
	input  wire logic [PHASES-1:0][CUR_W-1:0] phaseDelta,
	input  wire logic [CUR_W-2:0]          deltaLimit,
	input  wire logic [PHASES-1:0][ANG_W-1:0] phaseAngle,
	input  wire logic [ANG_W-1:0]          residualAngle,
	// settings
	input  efpc_group_type [GROUPS-1:0]    groupSettings,
	input  wire logic [MS_W-1:0]           inverseBaseMs,
	input  wire logic                      recordEnable,
	input  wire logic [TS_W-1:0]           timeStamp,
	// group selection
	input  efpc_select_type                groupSelectSource,
	input  wire logic [2:0]                groupSelectIndex,
	input  wire logic [1:0]                manualGroup,
	input  wire logic [1:0]                switchedGroup,
	input  wire logic [SEL_W-1:0]          digitalInputs,
	input  wire logic [SEL_W-1:0]          virtualInputs,
	input  wire logic [SEL_W-1:0]          indicatorSignals,
	input  wire logic [SEL_W-1:0]          virtualOutputs,
	// force and status writes
	input  wire logic                      forceOn,
	input  wire logic                      forceOff,
	input  wire logic                      statusWrite,
	input  wire logic                      statusStartValue,
	input  wire logic                      statusTripValue,
	// counter clears and log read
	input  wire logic                      startCountClear,
	input  wire logic                      tripCountClear,
	input  wire logic [2:0]                logReadIndex,
	// status outputs
	output logic                           startStatus,
	output logic                           tripStatus,
	output logic                           forceFlag,
	output logic [1:0]                     activeGroup,
	output logic [CNT_W-1:0]               startCount,
	output logic [CNT_W-1:0]               tripCount,
	output logic [PCT_W-1:0]               elapsedDelayPercent,
	// classification outputs
	output efpc_outcome_type               outcome,
	output logic                           faultEvent,
	output efpc_record_type                logReadData,
	output logic [3:0]                     logEntries
);
	if (TICK_CYCLES_P < 1 || FORCE_MS_P < 1) begin : g_check
		$error("tick and force timeout counts must be positive");
	end

	localparam int TW = $clog2(TICK_CYCLES_P + 1);
	localparam int FW = $clog2(FORCE_MS_P + 1);

	// synchroniser, tick divider and force flag
	logic [SEL_W-1:0] diMeta_reg, diSync_reg;
	logic [TW-1:0]    tick_reg, tick_next;
	logic             msTick;
	logic             force_reg, force_next;
	logic [FW-1:0]    forceMs_reg, forceMs_next;
	logic             held_reg, held_next;
	logic             heldStart_reg, heldStart_next;
	logic             heldTrip_reg, heldTrip_next;
	logic [1:0]       group_reg, group_next;
	logic             selBit;

	always_comb begin
		msTick         = (tick_reg == TW'(TICK_CYCLES_P - 1));
		tick_next      = msTick ? '0 : tick_reg + 1'b1;
		force_next     = force_reg;
		forceMs_next   = forceMs_reg;
		held_next      = held_reg;
		heldStart_next = heldStart_reg;
		heldTrip_next  = heldTrip_reg;
		if (forceOn) begin
			force_next   = 1'b1;
			forceMs_next = '0;
		end else if (forceOff) begin
			force_next = 1'b0;
		end else if (force_reg && msTick) begin
			forceMs_next = forceMs_reg + 1'b1;
			if (forceMs_reg == FW'(FORCE_MS_P - 1)) begin
				force_next = 1'b0;
			end
		end
		if (!force_next) begin
			held_next = 1'b0;
		end else if (statusWrite && force_reg) begin
			held_next      = 1'b1;
			heldStart_next = statusStartValue;
			heldTrip_next  = statusTripValue;
		end
		unique case (groupSelectSource)
			SEL_DIGITAL:     selBit = diSync_reg[groupSelectIndex];
			SEL_VIRTUAL_IN:  selBit = virtualInputs[groupSelectIndex];
			SEL_INDICATOR:   selBit = indicatorSignals[groupSelectIndex];
			SEL_VIRTUAL_OUT: selBit = virtualOutputs[groupSelectIndex];
			default:         selBit = 1'b0;
		endcase
		group_next = selBit ? switchedGroup : manualGroup;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			diMeta_reg    <= '0;
			diSync_reg    <= '0;
			tick_reg      <= '0;
			force_reg     <= 1'b0;
			forceMs_reg   <= '0;
			held_reg      <= 1'b0;
			heldStart_reg <= 1'b0;
			heldTrip_reg  <= 1'b0;
			group_reg     <= '0;
		end else begin
			diMeta_reg    <= digitalInputs;
			diSync_reg    <= diMeta_reg;
			tick_reg      <= tick_next;
			force_reg     <= force_next;
			forceMs_reg   <= forceMs_next;
			held_reg      <= held_next;
			heldStart_reg <= heldStart_next;
			heldTrip_reg  <= heldTrip_next;
			group_reg     <= group_next;
		end
	end

	// stage status, delay and counters
	efpc_group_type    gs;
	logic [CUR_W-1:0]  residual;
	logic [MS_W+7:0]   inverseProd;
	logic [MS_W-1:0]   operateMs;
	logic [MS_W-1:0]   elapsed_reg, elapsed_next;
	logic              overCurrent, startNow, tripNow;
	logic              startPrev_reg, tripPrev_reg;
	logic              startRise, startFall, tripRise;
	logic [CNT_W-1:0]  sCnt_reg, sCnt_next, tCnt_reg, tCnt_next;
	logic [PCT_W-1:0]  pct_reg, pct_next;
	logic [MS_W+7:0]   pctProd;

	always_comb begin
		gs = groupSettings[group_reg];
		unique case (residualSource)
			SRC_INPUT_TWO: residual = residualInputTwo;
			SRC_PHASE_SUM: residual = residualFromPhaseSum;
			default:       residual = residualInputOne;
		endcase
		overCurrent = residual > gs.pickup;
		inverseProd = (MS_W+8)'(inverseBaseMs * gs.multiplier) / (MS_W+8)'(K_SCALE);
		operateMs   = gs.definiteTime ? gs.operateMs : inverseProd[MS_W-1:0];
		elapsed_next = elapsed_reg;
		if (!overCurrent) begin
			elapsed_next = '0;
		end else if (msTick && elapsed_reg < operateMs) begin
			elapsed_next = elapsed_reg + 1'b1;
		end
		startNow  = held_reg ? heldStart_reg : overCurrent;
		tripNow   = held_reg ? heldTrip_reg : overCurrent && elapsed_reg >= operateMs;
		startRise = startNow && !startPrev_reg;
		startFall = !startNow && startPrev_reg;
		tripRise  = tripNow && !tripPrev_reg;
		pctProd   = (MS_W+8)'(elapsed_reg * PCT_FULL) / (MS_W+8)'(operateMs | MS_W'(tripNow));
		pct_next  = pct_reg;
		if (tripNow) begin
			pct_next = PCT_FULL;
		end else if (startNow && pctProd[PCT_W-1:0] > pct_reg) begin
			pct_next = pctProd[PCT_W-1:0];
		end else if (startRise) begin
			pct_next = '0;
		end
		sCnt_next = startCountClear ? '0 : sCnt_reg;
		tCnt_next = tripCountClear ? '0 : tCnt_reg;
		if (startRise) begin
			sCnt_next = sCnt_next + 1'b1;
		end
		if (tripRise) begin
			tCnt_next = tCnt_next + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			elapsed_reg   <= '0;
			startPrev_reg <= 1'b0;
			tripPrev_reg  <= 1'b0;
			sCnt_reg      <= '0;
			tCnt_reg      <= '0;
			pct_reg       <= '0;
		end else begin
			elapsed_reg   <= elapsed_next;
			startPrev_reg <= startNow;
			tripPrev_reg  <= tripNow;
			sCnt_reg      <= sCnt_next;
			tCnt_reg      <= tCnt_next;
			pct_reg       <= pct_next;
		end
	end

	// faulted phase classification and record
	logic [PHASES-1:0]         up, down, fwdNear, revNear, between;
	logic signed [ANG_W-1:0]   resAng, d1, d2;
	logic [CUR_W-1:0]          limitPos;
	logic [1:0]                upN, downN;
	efpc_outcome_type          cls, out_reg, out_next, faultOut_reg, faultOut_next;
	logic                      event_reg, event_next;
	logic [CUR_W-1:0]          max_reg, max_next;
	logic [TS_W-1:0]           stamp_reg, stamp_next;
	efpc_record_type           rec;

	always_comb begin
		limitPos = {1'b0, deltaLimit};
		resAng   = gs.capacitive ? angDiff(residualAngle, ANG_CAP) : residualAngle;
		for (int p = 0; p < PHASES; p++) begin
			up[p]      = $signed(phaseDelta[p]) > $signed(limitPos);
			down[p]    = $signed(phaseDelta[p]) < -$signed(limitPos);
			d1         = angDiff(resAng, phaseAngle[p]);
			fwdNear[p] = angAbs(d1) <= ANG_CONFIRM;
			revNear[p] = angAbs(angDiff(d1, ANG_REVERSE)) <= ANG_CONFIRM;
			d1         = angDiff(resAng, phaseAngle[p]);
			d2         = angDiff(phaseAngle[(p + 1) % PHASES], resAng);
			between[p] = (d1 >= 0 && d2 >= 0) || (d1 <= 0 && d2 <= 0);
		end
		upN   = 2'($countones(up));
		downN = 2'($countones(down));
		cls   = OUT_NONE;
		if (upN == 2'(PHASES)) begin
			cls = OUT_FORWARD_L123;
		end else if (downN == 2'(PHASES)) begin
			cls = OUT_REVERSE_THREE;
		end else if (upN == 2'd1 && downN == 2'd0) begin
			if (up[0] && fwdNear[0]) cls = OUT_FORWARD_L1;
			if (up[1] && fwdNear[1]) cls = OUT_FORWARD_L2;
			if (up[2] && fwdNear[2]) cls = OUT_FORWARD_L3;
		end else if (upN == 2'd2 && downN == 2'd0) begin
			if (up[0] && up[1] && between[0]) cls = OUT_FORWARD_L12;
			if (up[1] && up[2] && between[1]) cls = OUT_FORWARD_L23;
			if (up[2] && up[0] && between[2]) cls = OUT_FORWARD_L31;
		end else if (downN == 2'd1 && upN == 2'd0) begin
			if ((down & revNear) != '0) cls = OUT_REVERSE_ONE;
		end else if (downN == 2'd2 && upN == 2'd0) begin
			cls = OUT_REVERSE_TWO;
		end
		event_next    = startRise && overCurrent && recordEnable && cls != OUT_NONE;
		out_next      = event_next ? cls : out_reg;
		faultOut_next = event_next ? cls : (startRise ? OUT_NONE : faultOut_reg);
		max_next      = startRise ? residual : max_reg;
		if (startNow && residual > max_reg) begin
			max_next = residual;
		end
		stamp_next     = startRise ? timeStamp : stamp_reg;
		rec.stamp      = stamp_reg;
		rec.maxCurrent = max_reg;
		rec.elapsedPct = pct_reg;
		rec.group      = group_reg;
		rec.outcome    = faultOut_reg;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			out_reg      <= OUT_NONE;
			faultOut_reg <= OUT_NONE;
			event_reg    <= 1'b0;
			max_reg      <= '0;
			stamp_reg    <= '0;
		end else begin
			out_reg      <= out_next;
			faultOut_reg <= faultOut_next;
			event_reg    <= event_next;
			max_reg      <= max_next;
			stamp_reg    <= stamp_next;
		end
	end

	efpc_fault_log #(
		.DEPTH(LOG_DEPTH)
	) u_log (
		.clock      (clock),
		.reset_n    (reset_n),
		.writeEn    (startFall),
		.writeData  (rec),
		.readIndex  (logReadIndex),
		.readData   (logReadData),
		.entryCount (logEntries)
	);

	assign startStatus         = startPrev_reg;
	assign tripStatus          = tripPrev_reg;
	assign forceFlag           = force_reg;
	assign activeGroup         = group_reg;
	assign startCount          = sCnt_reg;
	assign tripCount           = tCnt_reg;
	assign elapsedDelayPercent = pct_reg;
	assign outcome             = out_reg;
	assign faultEvent          = event_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	chk_event_cause: assert property (faultEvent |-> $past(startRise && recordEnable))
		else $error("fault event without enabled start");
	chk_event_gated: assert property (!recordEnable && startRise |=> !faultEvent)
		else $error("fault event while recording disabled");
	chk_outcome_hold: assert property (!event_next |=> $stable(outcome))
		else $error("outcome changed without a recognised fault");
	chk_three_forward: assert property (startRise && overCurrent && recordEnable
		&& up == 3'b111 |=> outcome == OUT_FORWARD_L123)
		else $error("three raised phases not classified forward");
	chk_three_reverse: assert property (startRise && overCurrent && recordEnable
		&& down == 3'b111 |=> outcome == OUT_REVERSE_THREE)
		else $error("three fallen phases not classified reverse");
	chk_force_timeout: assert property (force_reg && msTick && !forceOn && !forceOff
		&& forceMs_reg == FW'(FORCE_MS_P - 1) |=> !forceFlag)
		else $error("force flag outlived its timeout");
	chk_status_write: assert property (!force_reg |=> !held_reg)
		else $error("status write accepted without force");
	chk_count_clear: assert property (startCountClear ##0 !startRise |=> startCount == '0)
		else $error("start counter did not clear");
	chk_trip_percent: assert property (!held_reg && $rose(tripNow) |=> elapsedDelayPercent == PCT_FULL)
		else $error("trip not shown as full delay");

	cov_forward_single: cover property (faultEvent && outcome == OUT_FORWARD_L1);
	cov_reverse_one: cover property (faultEvent && outcome == OUT_REVERSE_ONE);
	cov_trip: cover property (tripStatus && !held_reg);
	cov_force_expiry: cover property (force_reg ##1 !force_reg && !$past(forceOff));
endmodule : efpc_classifier

// >>> verif/efpc_front_model.sv
// measurement front end model: phase deltas, phase angles and residual magnitudes
module efpc_front_model
	import efpc_pkg::*;
(
	// clock
	input  wire logic                    clock,
	// scenario from bench
	input  wire logic [PHASES-1:0][1:0]  phaseDir,
	input  wire logic [ANG_W-1:0]        faultAngle,
	input  wire logic                    faultOn,
	input  wire logic [1:0]              faultSource,
	input  wire logic [CUR_W-2:0]        limit,
	// measurements
	output logic [PHASES-1:0][CUR_W-1:0] phaseDelta,
	output logic [PHASES-1:0][ANG_W-1:0] phaseAngle,
	output logic [ANG_W-1:0]             residualAngle,
	output logic [2:0][CUR_W-1:0]        residualMag
);
	timeunit 1ns;
	timeprecision 1ns;

	// delta inside, above or below the band, with random size
	function automatic logic [CUR_W-1:0] band(input logic [1:0] dir);
		logic [CUR_W-1:0] m;
		m = {1'b0, limit} + 16'h0001 + 16'($urandom % 200);
		if (dir == 2'b01) return m;
		if (dir == 2'b11) return -m;
		return 16'($urandom % limit) - 16'($urandom % limit);
	endfunction : band

	assign phaseAngle = {9'h078, 9'h188, 9'h000};

	always @(posedge clock) begin
		for (int i = 0; i < PHASES; i++) begin
			phaseDelta[i] <= band(phaseDir[i]);
		end
		for (int j = 0; j < 3; j++) begin
			residualMag[j] <= (faultOn && faultSource == 2'(j)) ?
				16'h4000 + 16'($urandom % 256) : 16'($urandom % 64);
		end
		residualAngle <= faultAngle;
	end
endmodule : efpc_front_model

// >>> verif/tb_top.sv
// top bench: stimulus, reference model and verdict for the classifier
module tb_top
	import efpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                         clock = 1'b0;
	logic                         reset_n = 1'b0;
	logic [PHASES-1:0][1:0]       phaseDir = '0;
	logic [ANG_W-1:0]             faultAngle = '0;
	logic                         faultOn = 1'b0;
	logic [1:0]                   faultSource = '0;
	efpc_source_type              residualSource = SRC_INPUT_ONE;
	logic [CUR_W-2:0]             deltaLimit = 15'h01f4;
	efpc_group_type [GROUPS-1:0]  groupSettings;
	logic                         recordEnable = 1'b1;
	logic [TS_W-1:0]              timeStamp = '0;
	efpc_select_type              groupSelectSource = SEL_NONE;
	logic [2:0]                   groupSelectIndex = '0;
	logic [1:0]                   manualGroup = '0;
	logic [1:0]                   switchedGroup = '0;
	logic [SEL_W-1:0]             selectBits = '0;
	logic                         forceOn = 1'b0;
	logic                         forceOff = 1'b0;
	logic                         statusWrite = 1'b0;
	logic                         statusStartValue = 1'b0;
	logic                         statusTripValue = 1'b0;
	logic                         startCountClear = 1'b0;
	logic                         tripCountClear = 1'b0;
	logic [PHASES-1:0][CUR_W-1:0] phaseDelta;
	logic [PHASES-1:0][ANG_W-1:0] phaseAngle;
	logic [ANG_W-1:0]             residualAngle;
	logic [2:0][CUR_W-1:0]        residualMag;
	logic                         startStatus, tripStatus, forceFlag, faultEvent;
	logic [1:0]                   activeGroup;
	logic [CNT_W-1:0]             startCount, tripCount;
	logic [PCT_W-1:0]             elapsedDelayPercent;
	efpc_outcome_type             outcome, lastOut = OUT_NONE;
	efpc_record_type              logReadData;
	logic [3:0]                   logEntries;
	int                           mismatches = 0;
	int                           totalChecks = 0;
	int                           startModel = 0;
	int                           k, n;
	int                           logModel[$];
	// phase directions (1 up, -1 down), residual angle, capacitive, recording
	int cases[14][6] = '{'{1,0,0,10,0,1}, '{0,1,0,-110,0,1}, '{0,0,1,130,0,1},
		'{1,1,0,-60,0,1}, '{0,1,1,170,0,1}, '{1,0,1,60,0,1}, '{1,1,1,0,0,1},
		'{-1,0,0,170,0,1}, '{-1,-1,0,0,0,1}, '{-1,-1,-1,0,0,1}, '{1,0,0,100,0,1},
		'{1,0,0,100,1,1}, '{0,-1,0,60,0,1}, '{1,0,0,10,0,0}};

	always #10 clock = ~clock;
	always @(posedge clock) timeStamp <= timeStamp + 48'h1;

	efpc_front_model efpc_front_model_i (.clock(clock), .phaseDir(phaseDir),
		.faultAngle(faultAngle), .faultOn(faultOn), .faultSource(faultSource),
		.limit(deltaLimit), .phaseDelta(phaseDelta), .phaseAngle(phaseAngle),
		.residualAngle(residualAngle), .residualMag(residualMag));

	efpc_classifier #(.TICK_CYCLES_P(4), .FORCE_MS_P(5)) efpc_classifier_i (
		.clock(clock), .reset_n(reset_n), .residualInputOne(residualMag[0]),
		.residualInputTwo(residualMag[1]), .residualFromPhaseSum(residualMag[2]),
		.residualSource(residualSource), .phaseDelta(phaseDelta), .deltaLimit(deltaLimit),
		.phaseAngle(phaseAngle), .residualAngle(residualAngle),
		.groupSettings(groupSettings), .inverseBaseMs(20'h00064),
		.recordEnable(recordEnable), .timeStamp(timeStamp),
		.groupSelectSource(groupSelectSource), .groupSelectIndex(groupSelectIndex),
		.manualGroup(manualGroup), .switchedGroup(switchedGroup),
		.digitalInputs(selectBits), .virtualInputs(selectBits),
		.indicatorSignals(selectBits), .virtualOutputs(selectBits), .forceOn(forceOn),
		.forceOff(forceOff), .statusWrite(statusWrite), .statusStartValue(statusStartValue),
		.statusTripValue(statusTripValue), .startCountClear(startCountClear),
		.tripCountClear(tripCountClear), .logReadIndex(3'h0), .startStatus(startStatus),
		.tripStatus(tripStatus), .forceFlag(forceFlag), .activeGroup(activeGroup),
		.startCount(startCount), .tripCount(tripCount),
		.elapsedDelayPercent(elapsedDelayPercent), .outcome(outcome),
		.faultEvent(faultEvent), .logReadData(logReadData), .logEntries(logEntries));

	function automatic int wrap(int a);
		while (a > 180) a -= 360;
		while (a < -180) a += 360;
		return a;
	endfunction : wrap

	// reference classification from phase directions and residual angle
	function automatic int classify(int d0, int d1, int d2, int ang, int cap);
		int d[3] = '{d0, d1, d2};
		int pa[3] = '{0, -120, 120};
		int nu = 0;
		int nd = 0;
		int r;
		int x;
		for (int i = 0; i < 3; i++) begin
			nu += (d[i] == 1);
			nd += (d[i] == -1);
		end
		r = wrap(ang - 90 * cap);
		if (nu == 3) return 7;
		if (nd == 3) return 10;
		if (nd == 2 && nu == 0) return 9;
		for (int i = 0; i < 3; i++) begin
			if (nu == 1 && nd == 0 && d[i] == 1) begin
				x = wrap(r - pa[i]);
				return ((x < 0 ? -x : x) <= 60) ? 1 + i : 0;
			end
			if (nd == 1 && nu == 0 && d[i] == -1) begin
				x = wrap(r - pa[i] - 180);
				return ((x < 0 ? -x : x) <= 60) ? 8 : 0;
			end
			if (nu == 2 && nd == 0 && d[i] == 0) begin
				x = wrap(r - pa[(i + 1) % 3]) * wrap(pa[(i + 2) % 3] - r);
				return (x > 0) ? 4 + (i + 1) % 3 : 0;
			end
		end
		return 0;
	endfunction : classify

	task automatic cmp_val(logic [47:0] got, logic [47:0] exp, string what);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_out(efpc_outcome_type got, efpc_outcome_type exp);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t outcome got %0d exp %0d", $time, got, exp);
		end
	endtask : cmp_out

	task automatic closeOut;
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : closeOut

	task automatic runCase(int i);
		int code;
		int seen;
		code = classify(cases[i][0], cases[i][1], cases[i][2], cases[i][3], cases[i][4]);
		phaseDir <= {2'(cases[i][2]), 2'(cases[i][1]), 2'(cases[i][0])};
		faultAngle <= ANG_W'(cases[i][3]);
		manualGroup <= 2'(cases[i][4]);
		recordEnable <= cases[i][5][0];
		faultSource <= 2'(i % 3);
		residualSource <= efpc_source_type'(i % 3);
		repeat (2) @(posedge clock);
		faultOn <= 1'b1;
		seen = 0;
		repeat (6) begin
			@(posedge clock);
			#1;
			seen += (faultEvent === 1'b1);
		end
		if (cases[i][5] != 0 && code != 0) lastOut = efpc_outcome_type'(code);
		startModel++;
		cmp_val(seen, (cases[i][5] != 0 && code != 0), "events");
		cmp_out(outcome, lastOut);
		cmp_val(startCount, startModel, "starts");
		cmp_val(activeGroup, cases[i][4], "group");
		@(posedge clock);
		faultOn <= 1'b0;
		logModel.push_front(cases[i][5] != 0 ? code : 0);
		repeat (6) @(posedge clock);
		#1;
		n = logModel.size();
		cmp_val(logEntries, n > LOG_DEPTH ? LOG_DEPTH : n, "entries");
		cmp_out(logReadData.outcome, efpc_outcome_type'(logModel[0]));
		cmp_val(logReadData.group, cases[i][4], "log group");
		cmp_val(logReadData.maxCurrent[15:8], 8'h40, "log max");
	endtask : runCase

	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		closeOut();
	end

	initial begin
		groupSettings[0] = '{16'h1000, 20'h003e8, 8'h64, 1'b1, 1'b0};
		groupSettings[1] = '{16'h1000, 20'h003e8, 8'h64, 1'b1, 1'b1};
		groupSettings[2] = '{16'h1000, 20'h00003, 8'h64, 1'b1, 1'b0};
		groupSettings[3] = '{16'h1000, 20'h00001, 8'h05, 1'b0, 1'b0};
		void'($urandom(32'h5155de3a));
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		#1;
		cmp_out(outcome, OUT_NONE);
		for (int i = 0; i < 14; i++) runCase(i);
		// residual above pickup on an unselected source
		@(posedge clock);
		manualGroup <= 2'h2;
		recordEnable <= 1'b0;
		faultSource <= 2'h0;
		residualSource <= SRC_INPUT_TWO;
		faultOn <= 1'b1;
		repeat (6) @(posedge clock);
		#1;
		cmp_val(startStatus, 0, "start off source");
		@(posedge clock);
		residualSource <= SRC_INPUT_ONE;
		n = 0;
		while (tripStatus !== 1'b1 && n < 60) begin
			@(posedge clock);
			#1;
			n++;
		end
		cmp_val(n >= 8 && n < 60, 1, "trip time");
		cmp_val(elapsedDelayPercent, 8'h64, "percent");
		cmp_val(tripCount, 1, "trips");
		cmp_val(startCount, startModel + 1, "starts");
		@(posedge clock);
		faultOn <= 1'b0;
		manualGroup <= 2'h3;
		repeat (3) @(posedge clock);
		faultOn <= 1'b1;
		n = 0;
		while (tripStatus !== 1'b1 && n < 60) begin
			@(posedge clock);
			#1;
			n++;
		end
		cmp_val(n > 18 && n <= 22, 1, "inverse trip");
		@(posedge clock);
		faultOn <= 1'b0;
		startCountClear <= 1'b1;
		tripCountClear <= 1'b1;
		@(posedge clock);
		startCountClear <= 1'b0;
		tripCountClear <= 1'b0;
		statusWrite <= 1'b1;
		statusStartValue <= 1'b1;
		statusTripValue <= 1'b1;
		@(posedge clock);
		statusWrite <= 1'b0;
		#1;
		cmp_val({startCount, tripCount}, 0, "cleared");
		repeat (6) @(posedge clock);
		#1;
		cmp_val({startStatus, tripStatus}, 0, "write unforced");
		@(posedge clock);
		forceOn <= 1'b1;
		@(posedge clock);
		forceOn <= 1'b0;
		statusWrite <= 1'b1;
		#1;
		cmp_val(forceFlag, 1, "force set");
		@(posedge clock);
		statusWrite <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		cmp_val(startStatus, 1, "forced start");
		cmp_val(tripStatus, 1, "forced trip");
		n = 0;
		while (forceFlag === 1'b1 && n < 100) begin
			@(posedge clock);
			#1;
			n++;
		end
		cmp_val(n >= 8 && n < 100, 1, "force timeout");
		repeat (3) @(posedge clock);
		#1;
		cmp_val({startStatus, tripStatus}, 0, "force released");
		@(posedge clock);
		forceOn <= 1'b1;
		@(posedge clock);
		forceOn <= 1'b0;
		forceOff <= 1'b1;
		@(posedge clock);
		forceOff <= 1'b0;
		#1;
		cmp_val(forceFlag, 0, "force off");
		for (int s = 1; s <= 4; s++) begin
			@(posedge clock);
			k = $urandom % 8;
			groupSelectSource <= efpc_select_type'(s);
			groupSelectIndex <= 3'(k);
			selectBits <= 8'h01 << k;
			switchedGroup <= 2'h3;
			manualGroup <= 2'h1;
			repeat (4) @(posedge clock);
			#1;
			cmp_val(activeGroup, 3, "switched group");
			@(posedge clock);
			selectBits <= 8'h00;
			repeat (4) @(posedge clock);
			#1;
			cmp_val(activeGroup, 1, "manual group");
		end
		closeOut();
	end
endmodule : tb_top
